// ### core/sfre_defs.vh
// constants shared by the serial flash command logic
`ifndef SFRE_DEFS_VH
`define SFRE_DEFS_VH
`define SFRE_REF_CLK_MHZ 200
`define SFRE_ARRAY_AW 21
`define SFRE_HALF_BLOCK_OP 8'h52
`define SFRE_SR_WIP 0
`define SFRE_SR_WEL 1
`define SFRE_SR_BP_LO 2
`define SFRE_SR_BP_HI 5
`define SFRE_SR_STATUS_WRITE_DISABLE 7
`define SFRE_SR_RESET 8'h00
`define SFRE_SMALL_WIPE_TIME_US 30
`define SFRE_HALF_BLOCK_WIPE_TIME_US 150
`define SFRE_LARGE_BLOCK_WIPE_TIME_US 300
`define SFRE_SMALL_MASK 21'h1ff000
`define SFRE_HALF_MASK 21'h1f8000
`define SFRE_LARGE_MASK 21'h1f0000
`define SFRE_ADDR_BITS 5'd23
`define SFRE_DUMMY_BITS 5'd7
`define SFRE_FIFO_DEPTH 4
`endif

// ### core/sfre_fifo.v
// small first-in first-out buffer between array fetch and serial output
`timescale 1ns/100ps
module sfre_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire ref_clk,
  input wire reset,
  input wire clear,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge ref_clk)
  begin
    if (reset || clear)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ### core/sfre_core.v
// serial flash command decoder: protection, reads and self-timed erases
`timescale 1ns/100ps
`include "sfre_defs.vh"
module sfre_core #(
  parameter [7:0] OP_READ = 8'h03,
  parameter [7:0] OP_FAST_READ = 8'h0b,
  parameter [7:0] OP_DUAL_READ = 8'h3b,
  parameter [7:0] OP_SMALL_WIPE = 8'h20,
  parameter [7:0] OP_LARGE_WIPE = 8'hd8,
  parameter [7:0] OP_WRITE_ENABLE = 8'h06,
  parameter [7:0] OP_READ_STATUS = 8'h05,
  parameter [31:0] SMALL_WIPE_CYC = `SFRE_SMALL_WIPE_TIME_US * `SFRE_REF_CLK_MHZ,
  parameter [31:0] HALF_WIPE_CYC = `SFRE_HALF_BLOCK_WIPE_TIME_US * `SFRE_REF_CLK_MHZ,
  parameter [31:0] LARGE_WIPE_CYC = `SFRE_LARGE_BLOCK_WIPE_TIME_US * `SFRE_REF_CLK_MHZ
) (
  input wire ref_clk,
  input wire reset,
  input wire sclk,
  input wire cs_n,
  input wire wp_n,
  input wire sio0_in,
  output reg sio0_out,
  output reg sio0_oe,
  output reg so_out,
  output reg so_oe,
  output reg [`SFRE_ARRAY_AW-1:0] mem_rd_addr,
  input wire [7:0] mem_rd_data,
  output reg erase_req,
  output reg [`SFRE_ARRAY_AW-1:0] erase_base,
  output reg [1:0] erase_size,
  input wire sr_wr_req,
  input wire [7:0] sr_wr_data,
  output reg sr_wr_reject,
  output reg write_in_progress,
  output reg write_enable_latch,
  output reg [3:0] block_protect_bits,
  output reg status_write_disable,
  output reg hardware_protect_mode,
  output reg software_protect_mode
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_CMD = 3'd1;
  localparam [2:0] ST_ADDR = 3'd2;
  localparam [2:0] ST_DUMMY = 3'd3;
  localparam [2:0] ST_DATA = 3'd4;
  localparam [2:0] ST_TAIL = 3'd5;
  localparam [2:0] ST_IGNORE = 3'd6;

  localparam [2:0] K_READ = 3'd0;
  localparam [2:0] K_FAST = 3'd1;
  localparam [2:0] K_DUAL = 3'd2;
  localparam [2:0] K_STATUS = 3'd3;
  localparam [2:0] K_SMALL = 3'd4;
  localparam [2:0] K_HALF = 3'd5;
  localparam [2:0] K_LARGE = 3'd6;
  localparam [2:0] K_WRITE_ENABLE_CMD = 3'd7;
  localparam [7:0] SR_RESET_VAL = `SFRE_SR_RESET;

  reg [3:0] pin1_reg;
  reg [3:0] pin2_reg;
  reg sclk_d_reg;
  reg cs_d_reg;
  reg [2:0] state_reg;
  reg [2:0] kind_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] cmd_sh_reg;
  reg [23:0] addr_reg;
  reg [7:0] out_sh_reg;
  reg [2:0] out_cnt_reg;
  reg fetch_on_reg;
  reg rd_pend_reg;
  reg [`SFRE_ARRAY_AW-1:0] fetch_addr_reg;
  reg [31:0] timer_reg;

  wire sclk_s = pin2_reg[0];
  wire cs_s = pin2_reg[1];
  wire si_s = pin2_reg[2];
  wire wp_s = pin2_reg[3];
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_rise = cs_s & ~cs_d_reg;
  wire hpm_now = status_write_disable & ~wp_s;
  wire [7:0] cmd_byte = {cmd_sh_reg[6:0], si_s};
  wire [7:0] status_byte;
  wire load_byte = sclk_fall && (state_reg == ST_DATA) && (out_cnt_reg == 3'd0);
  wire fifo_pop = load_byte && (kind_reg != K_STATUS);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [7:0] next_byte = (kind_reg == K_STATUS) ? status_byte : fifo_out_data;
  wire [`SFRE_ARRAY_AW-1:0] tgt = addr_reg[`SFRE_ARRAY_AW-1:0];

  assign status_byte = {status_write_disable, 1'b0, block_protect_bits,
                        write_enable_latch, write_in_progress};

  // top 2^(bp-1) 64K blocks are guarded; six or more covers the whole array
  function prot_hit;
    input [`SFRE_ARRAY_AW-1:0] a;
    input [3:0] bp;
    reg [5:0] blocks;
    begin
      blocks = 6'd0;
      if (bp != 4'd0)
      begin
        blocks = (bp >= 4'd6) ? 6'd32 : (6'd1 << (bp - 4'd1));
      end
      prot_hit = (bp != 4'd0) && ({1'b0, a[20:16]} >= (6'd32 - blocks));
    end
  endfunction

  function [`SFRE_ARRAY_AW-1:0] wipe_base;
    input [`SFRE_ARRAY_AW-1:0] a;
    input [2:0] k;
    begin
      case (k)
        K_SMALL: wipe_base = a & `SFRE_SMALL_MASK;
        K_HALF: wipe_base = a & `SFRE_HALF_MASK;
        default: wipe_base = a & `SFRE_LARGE_MASK;
      endcase
    end
  endfunction

  sfre_fifo #(
    .WIDTH(8),
    .DEPTH(`SFRE_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(state_reg == ST_IDLE),
    .in_valid(rd_pend_reg),
    .in_ready(fifo_in_ready),
    .in_data(mem_rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // all pins cross two flops before any decode looks at them
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      // idle pin levels, so no false clock edge follows reset
      pin1_reg <= 4'ha;
      pin2_reg <= 4'ha;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end
    else
    begin
      pin1_reg <= {wp_n, sio0_in, cs_n, sclk};
      pin2_reg <= pin1_reg;
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_s;
    end
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      kind_reg <= K_READ;
      bit_cnt_reg <= 5'd0;
      cmd_sh_reg <= 8'h00;
      addr_reg <= 24'h000000;
      out_sh_reg <= 8'h00;
      out_cnt_reg <= 3'd0;
      so_out <= 1'b0;
      so_oe <= 1'b0;
      sio0_out <= 1'b0;
      sio0_oe <= 1'b0;
      fetch_on_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      fetch_addr_reg <= {`SFRE_ARRAY_AW{1'b0}};
      mem_rd_addr <= {`SFRE_ARRAY_AW{1'b0}};
      erase_req <= 1'b0;
      erase_base <= {`SFRE_ARRAY_AW{1'b0}};
      erase_size <= 2'd0;
      timer_reg <= 32'd0;
      sr_wr_reject <= 1'b0;
      write_in_progress <= SR_RESET_VAL[`SFRE_SR_WIP];
      write_enable_latch <= SR_RESET_VAL[`SFRE_SR_WEL];
      block_protect_bits <= SR_RESET_VAL[`SFRE_SR_BP_HI:`SFRE_SR_BP_LO];
      status_write_disable <= SR_RESET_VAL[`SFRE_SR_STATUS_WRITE_DISABLE];
      hardware_protect_mode <= 1'b0;
      software_protect_mode <= 1'b1;
    end
    else
    begin
      erase_req <= 1'b0;
      // a status write that no branch below takes is refused, never lost
      sr_wr_reject <= sr_wr_req;
      hardware_protect_mode <= hpm_now;
      software_protect_mode <= ~hpm_now;
      if (cs_s)
      begin
        // select high ends any frame and releases the data lines
        state_reg <= ST_IDLE;
        so_oe <= 1'b0;
        sio0_oe <= 1'b0;
        fetch_on_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
      end
      else if (state_reg == ST_IDLE)
      begin
        state_reg <= ST_CMD;
        bit_cnt_reg <= 5'd0;
      end
      else if (sclk_rise)
      begin
        case (state_reg)
          ST_CMD:
          begin
            cmd_sh_reg <= cmd_byte;
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == 5'd7)
            begin
              bit_cnt_reg <= 5'd0;
              state_reg <= ST_IGNORE;
              if (cmd_byte == OP_READ && !write_in_progress)
              begin
                kind_reg <= K_READ;
                state_reg <= ST_ADDR;
              end
              else if (cmd_byte == OP_FAST_READ && !write_in_progress)
              begin
                kind_reg <= K_FAST;
                state_reg <= ST_ADDR;
              end
              else if (cmd_byte == OP_DUAL_READ && !write_in_progress)
              begin
                kind_reg <= K_DUAL;
                state_reg <= ST_ADDR;
              end
              else if (cmd_byte == OP_READ_STATUS)
              begin
                kind_reg <= K_STATUS;
                state_reg <= ST_DATA;
                out_cnt_reg <= 3'd0;
              end
              else if (cmd_byte == OP_WRITE_ENABLE && !write_in_progress)
              begin
                kind_reg <= K_WRITE_ENABLE_CMD;
                state_reg <= ST_TAIL;
              end
              else if (write_enable_latch && !write_in_progress)
              begin
                state_reg <= ST_ADDR;
                if (cmd_byte == OP_SMALL_WIPE)
                begin
                  kind_reg <= K_SMALL;
                end
                else if (cmd_byte == `SFRE_HALF_BLOCK_OP)
                begin
                  kind_reg <= K_HALF;
                end
                else if (cmd_byte == OP_LARGE_WIPE)
                begin
                  kind_reg <= K_LARGE;
                end
                else
                begin
                  state_reg <= ST_IGNORE;
                end
              end
            end
          end
          ST_ADDR:
          begin
            addr_reg <= {addr_reg[22:0], si_s};
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == `SFRE_ADDR_BITS)
            begin
              bit_cnt_reg <= 5'd0;
              out_cnt_reg <= 3'd0;
              if (kind_reg >= K_SMALL)
              begin
                state_reg <= ST_TAIL;
              end
              else
              begin
                // prefetch starts now so the dummy phase of fast and dual reads hides array latency; plain reads go straight to data
                fetch_on_reg <= 1'b1;
                fetch_addr_reg <= {addr_reg[`SFRE_ARRAY_AW-2:0], si_s};
                state_reg <= (kind_reg == K_READ) ? ST_DATA : ST_DUMMY;
              end
            end
          end
          ST_DUMMY:
          begin
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == `SFRE_DUMMY_BITS)
            begin
              state_reg <= ST_DATA;
            end
          end
          ST_TAIL:
          begin
            state_reg <= ST_IGNORE;
          end
          default:
          begin
            state_reg <= state_reg;
          end
        endcase
      end
      else if (load_byte)
      begin
        so_oe <= 1'b1;
        sio0_oe <= (kind_reg == K_DUAL);
        so_out <= next_byte[7];
        sio0_out <= next_byte[6];
        if (kind_reg == K_DUAL)
        begin
          out_sh_reg <= {next_byte[5:0], 2'b00};
          out_cnt_reg <= 3'd3;
        end
        else
        begin
          out_sh_reg <= {next_byte[6:0], 1'b0};
          out_cnt_reg <= 3'd7;
        end
      end
      else if (sclk_fall && state_reg == ST_DATA)
      begin
        so_out <= out_sh_reg[7];
        sio0_out <= out_sh_reg[6];
        out_cnt_reg <= out_cnt_reg - 3'd1;
        out_sh_reg <= (kind_reg == K_DUAL) ? {out_sh_reg[5:0], 2'b00}
                                           : {out_sh_reg[6:0], 1'b0};
      end

      // one read outstanding at a time, so the slot seen free stays free
      if (!cs_s)
      begin
        rd_pend_reg <= 1'b0;
        if (fetch_on_reg && !rd_pend_reg && fifo_in_ready)
        begin
          mem_rd_addr <= fetch_addr_reg;
          fetch_addr_reg <= fetch_addr_reg + 1'b1;
          rd_pend_reg <= 1'b1;
        end
      end

      if (cs_rise && state_reg == ST_TAIL && kind_reg == K_WRITE_ENABLE_CMD)
      begin
        write_enable_latch <= 1'b1;
      end
      else if (cs_rise && state_reg == ST_TAIL && bit_cnt_reg == 5'd0)
      begin
        if (prot_hit(tgt, block_protect_bits))
        begin
          write_enable_latch <= 1'b0;
        end
        else
        begin
          erase_req <= 1'b1;
          erase_base <= wipe_base(tgt, kind_reg);
          erase_size <= kind_reg[1:0];
          write_in_progress <= 1'b1;
          case (kind_reg)
            K_SMALL: timer_reg <= SMALL_WIPE_CYC - 32'd1;
            K_HALF: timer_reg <= HALF_WIPE_CYC - 32'd1;
            default: timer_reg <= LARGE_WIPE_CYC - 32'd1;
          endcase
        end
      end
      else if (write_in_progress)
      begin
        timer_reg <= timer_reg - 32'd1;
        if (timer_reg == 32'd0)
        begin
          write_in_progress <= 1'b0;
          write_enable_latch <= 1'b0;
        end
      end
      else if (sr_wr_req)
      begin
        if (write_enable_latch && !hpm_now)
        begin
          status_write_disable <= sr_wr_data[`SFRE_SR_STATUS_WRITE_DISABLE];
          block_protect_bits <= sr_wr_data[`SFRE_SR_BP_HI:`SFRE_SR_BP_LO];
          write_enable_latch <= 1'b0;
          sr_wr_reject <= 1'b0;
        end
        else
        begin
          sr_wr_reject <= 1'b1;
        end
      end
    end
  end
endmodule

// ### sim/sfre_core_checker.sv
// assertion checker for the serial flash command logic
`timescale 1ns/100ps
`include "sfre_defs.vh"
module sfre_core_checker (
  input wire ref_clk,
  input wire reset,
  input wire cs_n,
  input wire wp_n,
  input wire sio0_oe,
  input wire so_oe,
  input wire erase_req,
  input wire [`SFRE_ARRAY_AW-1:0] erase_base,
  input wire [1:0] erase_size,
  input wire sr_wr_req,
  input wire sr_wr_reject,
  input wire write_in_progress,
  input wire write_enable_latch,
  input wire [3:0] block_protect_bits,
  input wire status_write_disable,
  input wire hardware_protect_mode,
  input wire software_protect_mode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_wipe_start;
    erase_req ##0 write_in_progress;
  endsequence
  sequence s_wipe_hold;
    write_in_progress [*8];
  endsequence
  a_wipe_busy: assert property (erase_req |-> s_wipe_start ##1 s_wipe_hold)
    else $error("busy flag not held after erase start");
  a_wipe_latched: assert property (erase_req |-> $past(write_enable_latch))
    else $error("erase started with latch clear");
  a_base_aligned: assert property (erase_req |->
    (erase_size == 2'd0 && erase_base[11:0] == 12'h000) ||
    (erase_size == 2'd1 && erase_base[14:0] == 15'h0000) ||
    (erase_size == 2'd2 && erase_base[15:0] == 16'h0000))
    else $error("erase base or size malformed");
  a_no_restart: assert property (write_in_progress && $past(write_in_progress) |-> !erase_req)
    else $error("erase started while busy");
  a_done_unlatch: assert property ($fell(write_in_progress) |-> !write_enable_latch)
    else $error("latch still set after cycle end");
  a_mode_split: assert property (hardware_protect_mode != software_protect_mode)
    else $error("protect modes not exclusive");
  a_mode_cause: assert property (hardware_protect_mode |-> status_write_disable)
    else $error("hardware mode without disable bit");
  a_pin_high_free: assert property (wp_n [*5] |-> !hardware_protect_mode)
    else $error("hardware mode with pin high");
  a_bits_frozen: assert property (hardware_protect_mode && $past(hardware_protect_mode)
    |-> $stable(block_protect_bits) && $stable(status_write_disable))
    else $error("status bits changed in hardware mode");
  a_refuse_pulse: assert property (sr_wr_req && hardware_protect_mode |=> sr_wr_reject)
    else $error("status write not refused");
  a_quiet_deselect: assert property (cs_n [*8] |-> !so_oe && !sio0_oe)
    else $error("output driven while deselected");
endmodule
bind sfre_core sfre_core_checker i_chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .cs_n(cs_n),
  .wp_n(wp_n),
  .sio0_oe(sio0_oe),
  .so_oe(so_oe),
  .erase_req(erase_req),
  .erase_base(erase_base),
  .erase_size(erase_size),
  .sr_wr_req(sr_wr_req),
  .sr_wr_reject(sr_wr_reject),
  .write_in_progress(write_in_progress),
  .write_enable_latch(write_enable_latch),
  .block_protect_bits(block_protect_bits),
  .status_write_disable(status_write_disable),
  .hardware_protect_mode(hardware_protect_mode),
  .software_protect_mode(software_protect_mode)
);

// ### sim/sfre_host.sv
// host side serial controller model for the flash command logic
`timescale 1ns/100ps
module sfre_host (
  output logic sclk,
  output logic cs_n,
  output logic sio0_h,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic sio0_out,
  input wire logic sio0_oe
);
  logic [7:0] rx [0:3];
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sio0_h = 1'b1;
  end
  // data set while sclk is low, device samples on the rise
  task automatic put_bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      sio0_h = v[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nab,
    input int ndum, input int nby, input bit dual);
    logic [7:0] b;
    cs_n = 1'b0;
    #24;
    put_bits({op, a} >> (24 - nab), 8 + nab);
    for (int i = 0; i < ndum; i++)
      put_bits({31'd0, ~sio0_h}, 1);
    for (int k = 0; k < nby; k++)
    begin
      for (int j = 0; j < (dual ? 4 : 8); j++)
      begin
        // released line toggles so a stale level never reads back
        sio0_h = ~sio0_h;
        #24 sclk = 1'b1;
        if (dual)
          b = {b[5:0], so_oe ? so_out : 1'bz, sio0_oe ? sio0_out : 1'bz};
        else
          b = {b[6:0], so_oe ? so_out : 1'bz};
        #24 sclk = 1'b0;
      end
      rx[k] = b;
    end
    #24 cs_n = 1'b1;
    #48;
  endtask
endmodule

// ### sim/sfre_core_bench.sv
// self-checking bench for the serial flash command logic
`timescale 1ns/100ps
module sfre_core_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wp_n = 1'b1;
  logic sr_wr_req = 1'b0;
  logic [7:0] sr_wr_data = 8'h00;
  wire sclk, cs_n, sio0_h, sio0_out, sio0_oe, so_out, so_oe, erase_req, sr_wr_reject;
  wire write_in_progress, write_enable_latch, status_write_disable;
  wire hardware_protect_mode, software_protect_mode;
  wire [3:0] block_protect_bits;
  wire [1:0] erase_size;
  wire [20:0] mem_rd_addr, erase_base;
  wire [7:0] mem_rd_data;
  wire sio0_in = sio0_oe ? sio0_out : sio0_h;
  logic [511:0] wiped = '0;
  logic [22:0] last_wipe;
  logic [7:0] pop [0:2] = '{8'h20, 8'h52, 8'hd8};
  logic [23:0] padr [0:2] = '{24'h1ff000, 24'h1f8000, 24'h1f0000};
  int n_errors = 0;
  int cmp_count = 0;
  int n_wipes = 0;
  int n_rejects = 0;
  always #2.5 ref_clk = ~ref_clk;
  sfre_core #(.SMALL_WIPE_CYC(2000), .HALF_WIPE_CYC(300), .LARGE_WIPE_CYC(400)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .wp_n(wp_n),
    .sio0_in(sio0_in), .sio0_out(sio0_out), .sio0_oe(sio0_oe),
    .so_out(so_out), .so_oe(so_oe),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .erase_req(erase_req), .erase_base(erase_base), .erase_size(erase_size),
    .sr_wr_req(sr_wr_req), .sr_wr_data(sr_wr_data), .sr_wr_reject(sr_wr_reject),
    .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
    .block_protect_bits(block_protect_bits), .status_write_disable(status_write_disable),
    .hardware_protect_mode(hardware_protect_mode),
    .software_protect_mode(software_protect_mode)
  );
  sfre_host i_host (
    .sclk(sclk), .cs_n(cs_n), .sio0_h(sio0_h), .so_out(so_out), .so_oe(so_oe),
    .sio0_out(sio0_out), .sio0_oe(sio0_oe)
  );
  function automatic logic [7:0] pat(input logic [20:0] a);
    return a[7:0] ^ a[20:13];
  endfunction
  assign mem_rd_data = wiped[mem_rd_addr[20:12]] ? 8'hff : pat(mem_rd_addr);
  always @(posedge ref_clk)
  begin
    if (sr_wr_reject === 1'b1)
      n_rejects++;
    if (erase_req === 1'b1)
    begin
      n_wipes++;
      last_wipe <= {erase_size, erase_base};
      for (int s = 0; s < 512; s++)
        if ((s[8:0] & (erase_size == 2'd0 ? 9'h1ff : erase_size == 2'd1 ? 9'h1f8 : 9'h1f0))
          == erase_base[20:12])
          wiped[s] <= 1'b1;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_idle;
    int t;
    for (t = 0; t < 5000 && write_in_progress !== 1'b0; t++)
      @(posedge ref_clk);
    if (t == 5000)
    begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  task automatic write_enable_cmd;
    i_host.frame(8'h06, 24'h0, 0, 0, 0, 1'b0);
  endtask
  task automatic erase(input logic [7:0] op, input logic [23:0] a, input int nab, input bit we);
    if (we)
      write_enable_cmd;
    i_host.frame(op, a, nab, 0, 0, 1'b0);
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic status_wr(input logic [7:0] v);
    @(posedge ref_clk);
    sr_wr_req <= 1'b1;
    sr_wr_data <= v;
    @(posedge ref_clk);
    sr_wr_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic read_chk(input logic [7:0] op, input logic [20:0] a, input int ndum,
    input bit dual, input bit blank);
    i_host.frame(op, {3'b000, a}, 24, ndum, 3, dual);
    for (int k = 0; k < 3; k++)
      check("read byte", i_host.rx[k], blank ? 8'hff : pat(a + 21'(k)));
  endtask
  task automatic busy_read(input logic [7:0] op, input bit dual);
    i_host.frame(op, 24'h000100, 24, 8, 1, dual);
    check("refused read", i_host.rx[0], 8'hzz);
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("idle flags", {write_in_progress, write_enable_latch, block_protect_bits,
      status_write_disable, hardware_protect_mode, software_protect_mode}, 9'h001);
    read_chk(8'h03, 21'h1ffffe, 0, 1'b0, 1'b0);
    read_chk(8'h0b, 21'h000100, 8, 1'b0, 1'b0);
    read_chk(8'h3b, 21'h0007ff, 8, 1'b1, 1'b0);
    erase(8'h20, 24'h001234, 24, 1'b0);
    check("unlatched erase", n_wipes, 0);
    erase(8'h20, 24'h001234, 23, 1'b1);
    check("cut erase", n_wipes, 0);
    // one clock too many after the address must also void the erase
    i_host.frame(8'h20, 24'h001234, 24, 1, 0, 1'b0);
    check("long erase", n_wipes, 0);
    i_host.frame(8'h20, 24'h001234, 24, 0, 0, 1'b0);
    i_host.frame(8'h05, 24'h0, 0, 0, 1, 1'b0);
    check("status while busy", i_host.rx[0][1:0], 2'b11);
    busy_read(8'h0b, 1'b0);
    busy_read(8'h3b, 1'b1);
    check("busy held", write_in_progress, 1'b1);
    wait_idle;
    check("latch after erase", write_enable_latch, 1'b0);
    check("sector wipe", last_wipe, {2'd0, 21'h001000});
    read_chk(8'h03, 21'h001ffd, 0, 1'b0, 1'b1);
    read_chk(8'h03, 21'h002000, 0, 1'b0, 1'b0);
    erase(8'h52, 24'h0a1234, 24, 1'b1);
    check("half block", last_wipe, {2'd1, 21'h0a0000});
    wait_idle;
    read_chk(8'h03, 21'h0a7ffd, 0, 1'b0, 1'b1);
    read_chk(8'h03, 21'h0a8000, 0, 1'b0, 1'b0);
    erase(8'hd8, 24'h0c5678, 24, 1'b1);
    check("large block", last_wipe, {2'd2, 21'h0c0000});
    wait_idle;
    read_chk(8'h03, 21'h0cfffd, 0, 1'b0, 1'b1);
    write_enable_cmd;
    // pin stays high across this write
    status_wr(8'h84);
    check("protect set", {status_write_disable, block_protect_bits, write_enable_latch},
      6'b100010);
    for (int i = 0; i < 3; i++)
    begin
      erase(pop[i], padr[i], 24, 1'b1);
      check("guarded wipe", n_wipes, 3);
      check("guarded flags", {write_in_progress, write_enable_latch}, 2'b00);
    end
    read_chk(8'h03, 21'h1ffffd, 0, 1'b0, 1'b0);
    wp_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check("hardware mode", {hardware_protect_mode, software_protect_mode}, 2'b10);
    write_enable_cmd;
    status_wr(8'h00);
    check("reject count", n_rejects, 1);
    check("frozen bits", {block_protect_bits, status_write_disable}, 5'b00011);
    wp_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("mode left", {hardware_protect_mode, software_protect_mode}, 2'b01);
    write_enable_cmd;
    status_wr(8'h00);
    check("unprotected", {block_protect_bits, status_write_disable}, 5'b00000);
    tally_and_finish;
  end
endmodule
